// >>> rtl/nim_top.v
// nested interrupt mapper with external sense front end and APB slave
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
`include "nim_consts.vh"
module nim_top #(
  parameter NPER = 8
) (
  // clock and reset
  input  wire        CLK,
  input  wire        RSTN,
  // apb slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output wire        PREADY,
  output reg  [31:0] PRDATA,
  output wire        PSLVERR,
  // pins
  input  wire        TOP_PIN,
  input  wire [3:0]  PORTA_PINS,
  input  wire [2:0]  PORTF_PINS,
  input  wire [7:0]  PORTB_PINS,
  // pin selection from the port blocks
  input  wire [3:0]  PORTA_SEL,
  input  wire [2:0]  PORTF_SEL,
  input  wire [7:0]  PORTB_SEL,
  // peripheral requests, bit n = source n, same clock domain
  input  wire [13:0] PERIPH_REQ,
  input  wire        SYNC_SER_SLAVE,
  input  wire        ART_EXT_CLOCK,
  input  wire        HALTED,
  // cpu side
  input  wire        TRAP_REQ,
  input  wire        ACK,
  input  wire [3:0]  ACK_SRC,
  output reg         IRQ,
  output reg  [3:0]  IRQ_SRC,
  output reg  [15:0] IRQ_VECTOR,
  output reg  [1:0]  IRQ_LEVEL,
  output reg         WAKE
);

  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisation

  reg        rst_meta;
  reg        rst_n;
  wire       top_s;
  wire [3:0] pa_s;
  wire [2:0] pf_s;
  wire [7:0] pb_s;

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  nim_sync2 #(.W(16)) u_sync (
    .clk   (CLK),
    .rst_n (rst_n),
    .din   ({TOP_PIN, PORTA_PINS, PORTF_PINS, PORTB_PINS}),
    .dout  ({top_s, pa_s, pf_s, pb_s})
  );

  ////////////////////////////////////////////////////////////////////////
  // functions

  // larger value means higher level; maps the odd two-bit encoding
  function [1:0] lvl_rank;
    input [1:0] code;
    begin
      case (code)
        `NIM_LVL0: lvl_rank = 2'd0;
        `NIM_LVL1: lvl_rank = 2'd1;
        `NIM_LVL2: lvl_rank = 2'd2;
        default:   lvl_rank = 2'd3;
      endcase
    end
  endfunction

  // keep each pair whose new value is the level-0 code
  function [7:0] prio_merge;
    input [7:0] old_v;
    input [7:0] new_v;
    integer k;
    begin
      prio_merge = new_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (new_v[2*k+1 -: 2] == `NIM_LVL0)
          prio_merge[2*k+1 -: 2] = old_v[2*k+1 -: 2];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers

  reg  [7:0]  prio0;
  reg  [7:0]  prio1;
  reg  [7:0]  prio2;
  reg  [3:0]  prio3;
  reg  [7:0]  ext_ctl;
  reg  [1:0]  cur_level;
  reg  [13:0] per_en;
  reg         top_latched;
  reg         top_q;
  reg         clear_ext;
  wire [7:0]  idx;
  wire        wr;
  wire        at_lvl3;
  wire [7:0]  next_ext_ctl;
  wire [27:0] prio_all;
  wire [7:0]  prio3_merged;

  assign idx     = PADDR[9:2];
  assign wr      = PSEL & PENABLE & PWRITE;
  assign PREADY  = 1'b1;
  assign PSLVERR = 1'b0;
  assign at_lvl3 = (cur_level == `NIM_LVL3);
  assign prio_all = {prio3, prio2, prio1, prio0};
  // upper pairs forced to ones so only the two live pairs can be refused
  assign prio3_merged = prio_merge({`NIM_PRIO3_FIXED, prio3},
                                   {`NIM_PRIO3_FIXED, PWDATA[3:0]});

  // sense and polarity bits frozen outside level 3; edge select frozen
  // while the top pin is enabled; enable always free
  assign next_ext_ctl = {
    at_lvl3 ? PWDATA[`NIM_B_SENSE_HI:`NIM_A_POL]
            : ext_ctl[`NIM_B_SENSE_HI:`NIM_A_POL],
    ext_ctl[`NIM_TOP_EN] ? ext_ctl[`NIM_TOP_EDGE]
                         : PWDATA[`NIM_TOP_EDGE],
    PWDATA[`NIM_TOP_EN]};

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      prio0     <= `NIM_PRIO_RESET;
      prio1     <= `NIM_PRIO_RESET;
      prio2     <= `NIM_PRIO_RESET;
      prio3     <= `NIM_PRIO3_FIXED;
      ext_ctl   <= `NIM_EXTCTL_RESET;
      cur_level <= `NIM_LVL3;
      per_en    <= 14'h0000;
      clear_ext <= 1'b0;
    end else begin
      clear_ext <= 1'b0;
      if (wr) begin
        case (idx)
          `NIM_IDX_PRIO0: prio0 <= prio_merge(prio0, PWDATA[7:0]);
          `NIM_IDX_PRIO1: prio1 <= prio_merge(prio1, PWDATA[7:0]);
          `NIM_IDX_PRIO2: prio2 <= prio_merge(prio2, PWDATA[7:0]);
          `NIM_IDX_PRIO3: prio3 <= prio3_merged[3:0];
          `NIM_IDX_EXTCTL: begin
            ext_ctl <= next_ext_ctl;
            if (next_ext_ctl[`NIM_B_SENSE_HI:`NIM_A_POL] !=
                ext_ctl[`NIM_B_SENSE_HI:`NIM_A_POL])
              clear_ext <= 1'b1;
          end
          `NIM_IDX_CPUCTL: begin
            cur_level <= PWDATA[1:0];
            per_en    <= PWDATA[29:16];
          end
          default: ;
        endcase
      end else if (ACK) begin
        // entering a routine raises the level to that source's own
        cur_level <= IRQ_LEVEL;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // top-level pin and external lines

  wire       top_sel_edge;
  wire [3:0] ext_req;

  assign top_sel_edge = ext_ctl[`NIM_TOP_EDGE] ? (top_s & ~top_q)
                                               : (~top_s & top_q);

  // the enable does not gate the edge detector, so clearing it can leave
  // a stale latched request behind; accepted as documented
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      top_q       <= 1'b1;
      top_latched <= 1'b0;
    end else begin
      top_q <= top_s;
      if (top_sel_edge && ext_ctl[`NIM_TOP_EN])
        top_latched <= 1'b1;
      else if (ACK && ACK_SRC == `NIM_SRC_TOP)
        top_latched <= 1'b0;
    end
  end

  // four lines; pair order gives source numbers 2..5
  nim_ext_line #(.PINS(4)) u_line_a (
    .clk     (CLK),
    .rst_n   (rst_n),
    .pins    (pa_s),
    .pin_sel (PORTA_SEL),
    .sense   (ext_ctl[`NIM_A_SENSE_HI:`NIM_A_SENSE_LO]),
    .invert  (ext_ctl[`NIM_A_POL]),
    .clear   (clear_ext),
    .ack     (ACK && ACK_SRC == 4'h2),
    .req     (ext_req[0])
  );

  nim_ext_line #(.PINS(3)) u_line_f (
    .clk     (CLK),
    .rst_n   (rst_n),
    .pins    (pf_s),
    .pin_sel (PORTF_SEL),
    .sense   (ext_ctl[`NIM_A_SENSE_HI:`NIM_A_SENSE_LO]),
    .invert  (1'b0),
    .clear   (clear_ext),
    .ack     (ACK && ACK_SRC == 4'h3),
    .req     (ext_req[1])
  );

  nim_ext_line #(.PINS(4)) u_line_bl (
    .clk     (CLK),
    .rst_n   (rst_n),
    .pins    (pb_s[3:0]),
    .pin_sel (PORTB_SEL[3:0]),
    .sense   (ext_ctl[`NIM_B_SENSE_HI:`NIM_B_SENSE_LO]),
    .invert  (ext_ctl[`NIM_B_POL]),
    .clear   (clear_ext),
    .ack     (ACK && ACK_SRC == 4'h4),
    .req     (ext_req[2])
  );

  nim_ext_line #(.PINS(4)) u_line_bh (
    .clk     (CLK),
    .rst_n   (rst_n),
    .pins    (pb_s[7:4]),
    .pin_sel (PORTB_SEL[7:4]),
    .sense   (ext_ctl[`NIM_B_SENSE_HI:`NIM_B_SENSE_LO]),
    .invert  (1'b0),
    .clear   (clear_ext),
    .ack     (ACK && ACK_SRC == 4'h5),
    .req     (ext_req[3])
  );

  ////////////////////////////////////////////////////////////////////////
  // arbitration

  wire [13:0] pend;
  wire [13:0] wake_cap;
  reg  [13:0] eligible;
  reg  [3:0]  win;
  reg  [3:0]  wake_win;
  reg         found;
  reg         wfound;
  reg  [1:0]  win_lvl;
  integer     s;

  assign pend = {PERIPH_REQ[13:7] & per_en[13:7], 1'b0, ext_req,
                 PERIPH_REQ[1] & per_en[1], top_latched};

  // slot 6 unused, trap/timers/serial/detector/bus never wake
  assign wake_cap = {ART_EXT_CLOCK, 5'b00000, SYNC_SER_SLAVE,
                     7'b0111111};

  always @* begin
    eligible = 14'h0000;
    win      = `NIM_SRC_NONE;
    wake_win = `NIM_SRC_NONE;
    found    = 1'b0;
    wfound   = 1'b0;
    win_lvl  = 2'd0;
    // top pin ignores the current level, others must exceed it
    for (s = 0; s < `NIM_NUM_SRC; s = s + 1) begin
      eligible[s] = pend[s] && ((s == 0) ||
        (lvl_rank(prio_all[2*s+1 -: 2]) > lvl_rank(cur_level)));
    end
    // scan high to low so the lowest number of the highest level is left holding
    for (s = `NIM_NUM_SRC - 1; s >= 0; s = s - 1) begin
      if (eligible[s] && (s == 0 ||
          lvl_rank(prio_all[2*s+1 -: 2]) >= win_lvl || !found)) begin
        found   = 1'b1;
        win     = s[3:0];
        win_lvl = (s == 0) ? 2'd3 : lvl_rank(prio_all[2*s+1 -: 2]);
      end
      if (pend[s] && wake_cap[s]) begin
        wfound   = 1'b1;
        wake_win = s[3:0];
      end
    end
    // leaving halt, the first served must be a wake-capable source
    if (HALTED) begin
      found = wfound && eligible[wake_win];
      win   = wake_win;
    end
  end

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      IRQ        <= 1'b0;
      IRQ_SRC    <= `NIM_SRC_NONE;
      IRQ_VECTOR <= `NIM_VEC_RESET;
      IRQ_LEVEL  <= `NIM_LVL3;
      WAKE       <= 1'b0;
    end else begin
      WAKE <= wfound;
      if (TRAP_REQ && !(found && win == `NIM_SRC_TOP)) begin
        IRQ        <= 1'b1;
        IRQ_SRC    <= `NIM_SRC_NONE;
        IRQ_VECTOR <= `NIM_VEC_TRAP;
        IRQ_LEVEL  <= `NIM_LVL3;
      end else begin
        IRQ        <= found && !ACK;
        IRQ_SRC    <= found ? win : `NIM_SRC_NONE;
        IRQ_VECTOR <= `NIM_VEC_TOP - {11'h000, win, 1'b0};
        IRQ_LEVEL  <= (!found || win == `NIM_SRC_TOP) ? `NIM_LVL3
                                                      : prio_all[2*win+1 -: 2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux

  always @* begin
    PRDATA = 32'h00000000;
    case (idx)
      `NIM_IDX_PRIO0:  PRDATA[7:0] = prio0;
      `NIM_IDX_PRIO1:  PRDATA[7:0] = prio1;
      `NIM_IDX_PRIO2:  PRDATA[7:0] = prio2;
      `NIM_IDX_PRIO3:  PRDATA[7:0] = {4'hF, prio3};
      `NIM_IDX_EXTCTL: PRDATA[7:0] = ext_ctl;
      `NIM_IDX_CPUCTL: PRDATA = {2'b00, per_en, 14'h0000, cur_level};
      `NIM_IDX_STATUS: PRDATA = {16'h0000, 2'b00, pend};
      `NIM_IDX_VECTOR: PRDATA = {IRQ, 7'h00, 4'h0, IRQ_SRC, IRQ_VECTOR};
      default:         PRDATA = 32'h00000000;
    endcase
  end
endmodule

// >>> pkg/nim_consts.vh
// constants for the nested interrupt mapper and external sense front end
`ifndef NIM_CONSTS_VH
`define NIM_CONSTS_VH

// register indices (printed offsets), byte address is four times these
`define NIM_IDX_PRIO0      8'h24
`define NIM_IDX_PRIO1      8'h25
`define NIM_IDX_PRIO2      8'h26
`define NIM_IDX_PRIO3      8'h27
`define NIM_IDX_EXTCTL     8'h28
// own registers
`define NIM_IDX_CPUCTL     8'h29
`define NIM_IDX_STATUS     8'h2A
`define NIM_IDX_VECTOR     8'h2B

// reset values
`define NIM_PRIO_RESET     8'hFF
`define NIM_EXTCTL_RESET   8'h00
`define NIM_PRIO3_FIXED    4'hF

// ext_irq_control field positions
`define NIM_B_SENSE_HI     7
`define NIM_B_SENSE_LO     6
`define NIM_B_POL          5
`define NIM_A_SENSE_HI     4
`define NIM_A_SENSE_LO     3
`define NIM_A_POL          2
`define NIM_TOP_EDGE       1
`define NIM_TOP_EN         0

// two-bit level codes
`define NIM_LVL0           2'b10
`define NIM_LVL1           2'b01
`define NIM_LVL2           2'b00
`define NIM_LVL3           2'b11

// sensitivity codes
`define NIM_SENSE_FALL_LOW 2'b00
`define NIM_SENSE_RISE     2'b01
`define NIM_SENSE_FALL     2'b10
`define NIM_SENSE_BOTH     2'b11

// vectors
`define NIM_VEC_RESET      16'hFFFE
`define NIM_VEC_TRAP       16'hFFFC
`define NIM_VEC_TOP        16'hFFFA
`define NIM_NUM_SRC        14
`define NIM_SRC_TOP        4'h0
`define NIM_SRC_UNUSED     4'h6
`define NIM_SRC_SYNC_SER   7
`define NIM_SRC_ART        13
`define NIM_SRC_NONE       4'hF

`endif

// >>> rtl/nim_sync2.v
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/10ps
module nim_sync2 #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // data
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] stage1;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule

// >>> rtl/nim_ext_line.v
// one external line: OR of group pins, edge/level sense, latched request
`timescale 1ns/10ps
`include "nim_consts.vh"
module nim_ext_line #(
  parameter PINS = 4
) (
  // clock and reset
  input  wire            clk,
  input  wire            rst_n,
  // synchronised pins and pin selection
  input  wire [PINS-1:0] pins,
  input  wire [PINS-1:0] pin_sel,
  // configuration
  input  wire [1:0]      sense,
  input  wire            invert,
  // request handling
  input  wire            clear,
  input  wire            ack,
  output wire            req
);
  wire any_sel;
  wire line_raw;
  wire line;
  reg  raw_q;
  reg  latched;
  wire rise;
  wire fall;
  reg  hit;
  reg  level_on;

  assign any_sel  = |pin_sel;
  assign line_raw = |(pins & pin_sel);
  // polarity inversion swaps edges and the level, same as inverting the pin;
  // edges come from the raw line so a polarity write is never an edge
  assign line = line_raw ^ invert;
  assign rise = invert ? (~line_raw & raw_q) : (line_raw & ~raw_q);
  assign fall = invert ? (line_raw & ~raw_q) : (~line_raw & raw_q);

  always @* begin
    hit      = 1'b0;
    level_on = 1'b0;
    case (sense)
      `NIM_SENSE_FALL_LOW: begin
        hit      = fall;
        level_on = ~line;
      end
      `NIM_SENSE_RISE: hit = rise;
      `NIM_SENSE_FALL: hit = fall;
      `NIM_SENSE_BOTH: hit = rise | fall;
      default:         hit = 1'b0;
    endcase
  end

  // a group with no pin selected stays quiet, whatever its sense mode
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_q   <= 1'b0;
      latched <= 1'b0;
    end else begin
      raw_q <= line_raw;
      if (hit && any_sel)
        latched <= 1'b1;
      else if (clear || ack)
        latched <= 1'b0;
    end
  end

  assign req = latched | (level_on & any_sel);
endmodule

// >>> tb/nim_checker.sv
// port-level assertions for the interrupt mapper top
`timescale 1ns/10ps
module nim_checker (
  // clock and reset
  input wire logic        CLK, RSTN,
  // apb
  input wire logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA, PRDATA,
  // cpu side
  input wire logic        ACK, IRQ,
  input wire logic [3:0]  IRQ_SRC,
  input wire logic [15:0] IRQ_VECTOR,
  input wire logic [1:0]  IRQ_LEVEL
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic [1:0] lvl;
  logic [7:0] ext;
  wire        wr = PSEL && PENABLE && PWRITE;
  wire        rd = PSEL && PENABLE && !PWRITE;
  wire [7:0]  idx = PADDR[9:2];
  //////////////////////////////////////////////////////////////////////////
  // shadow of current level and control byte, built from bus writes and the level taken on ACK
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      lvl <= 2'h3;
      ext <= 8'h00;
    end else begin
      if (wr && idx == 8'h29) lvl <= PWDATA[1:0];
      else if (ACK) lvl <= IRQ_LEVEL;
      if (wr && idx == 8'h28) begin
        if (lvl == 2'h3) ext[7:2] <= PWDATA[7:2];
        if (!ext[0]) ext[1] <= PWDATA[1];
        ext[0] <= PWDATA[0];
      end
    end
  end
  sequence s_prio_rd;
    rd && idx >= 8'h24 && idx <= 8'h27;
  endsequence
  sequence s_held_reset;
    (!IRQ && IRQ_SRC == 4'hF && IRQ_VECTOR == 16'hFFFE) [*2];
  endsequence
  //////////////////////////////////////////////////////////////////////////
  a_zero_wait: assert property (PSEL && PENABLE |-> PREADY && !PSLVERR)
    else $error("apb access not answered at once");
  a_unmapped_zero: assert property (rd && (idx < 8'h24 || idx > 8'h2B)
    |-> PRDATA == 32'h0) else $error("unmapped read not zero");
  a_ext_readback: assert property (
    rd && idx == 8'h28 |-> PRDATA[7:0] == ext)
    else $error("control byte differs from shadow");
  a_prio_no_lvl0: assert property (
    s_prio_rd |-> PRDATA[7:6] != 2'h2 && PRDATA[5:4] != 2'h2 &&
    PRDATA[3:2] != 2'h2 && PRDATA[1:0] != 2'h2)
    else $error("level 0 code stored in a priority pair");
  a_prio3_upper: assert property (
    rd && idx == 8'h27 |-> PRDATA[7:4] == 4'hF)
    else $error("upper nibble of last priority byte not ones");
  a_vec_map: assert property (
    IRQ && IRQ_SRC <= 4'hD |->
    IRQ_VECTOR == 16'hFFFA - {11'h0, IRQ_SRC, 1'b0})
    else $error("vector does not match source");
  a_trap_vec: assert property (
    IRQ && IRQ_SRC == 4'hF |-> IRQ_VECTOR == 16'hFFFC)
    else $error("trap vector wrong");
  a_unused_slot: assert property (IRQ |-> IRQ_SRC != 4'h6)
    else $error("unused slot raised");
  a_fixed_lvl3: assert property (
    IRQ && (IRQ_SRC == 4'h0 || IRQ_SRC == 4'hF) |-> IRQ_LEVEL == 2'h3)
    else $error("top pin or trap not at level 3");
  a_no_lvl0_irq: assert property (
    IRQ && IRQ_SRC != 4'h0 && IRQ_SRC != 4'hF |-> IRQ_LEVEL != 2'h2)
    else $error("request served at level 0");
  a_reset_out: assert property ($rose(RSTN) |-> s_held_reset)
    else $error("outputs left reset state too early");
endmodule
bind nim_top nim_checker u_chk (
  .CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .ACK(ACK), .IRQ(IRQ), .IRQ_SRC(IRQ_SRC),
  .IRQ_VECTOR(IRQ_VECTOR), .IRQ_LEVEL(IRQ_LEVEL));

// >>> tb/nim_cpu_model.sv
// behavioural cpu core that enters the routine of a raised request
`timescale 1ns/10ps
module nim_cpu_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // bench control
  input  wire logic       en,
  input  wire logic [2:0] dly,
  // request side
  input  wire logic       irq,
  input  wire logic [3:0] irq_src,
  output logic            ack,
  output logic [3:0]      ack_src
);
  logic [2:0] cnt;
  // source id wanders while idle so a stale id never looks valid
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      ack_src <= 4'h0;
      cnt <= 3'h0;
    end else begin
      ack <= 1'b0;
      ack_src <= ack_src + 4'h1;
      cnt <= 3'h0;
      if (en && irq && !ack) begin
        cnt <= cnt + 3'h1;
        if (cnt == dly) begin
          ack <= 1'b1;
          ack_src <= irq_src;
        end
      end
    end
  end
endmodule

// >>> tb/nested_irq_mapper_ext_sense_bench.sv
// self-checking bench for the interrupt mapper and external sense block
`timescale 1ns/10ps
module nested_irq_mapper_ext_sense_bench;
  logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic        pready, top = 0, halted = 0, trap = 0, slave = 0;
  logic        extck = 0, ben = 0, ack, irq, wake, g, pol, dir, e0, e1;
  logic [3:0]  pa = 4'hF, pa_sel = 0, sel, p0, p1, ack_src, isrc;
  logic [7:0]  pb = 8'hFF, pb_sel = 0, cfg;
  logic [13:0] per = 0;
  logic [15:0] vec;
  logic [2:0]  dly = 0;
  logic [2:0]  pf = 3'h7, pf_sel = 0;
  logic [1:0]  code;
  int fail_count = 0, checked = 0, prio[4], ext = 0, n, k, d;
  int srcs[8] = '{1, 7, 8, 9, 10, 11, 12, 13};
  int tw[3] = '{8'h92, 8'h93, 8'h91};

  always #2.5 clk = ~clk;

  nim_top #(.NPER(8)) dut (
    .CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(), .TOP_PIN(top), .PORTA_PINS(pa), .PORTF_PINS(pf),
    .PORTB_PINS(pb), .PORTA_SEL(pa_sel), .PORTF_SEL(pf_sel),
    .PORTB_SEL(pb_sel), .PERIPH_REQ(per), .SYNC_SER_SLAVE(slave),
    .ART_EXT_CLOCK(extck), .HALTED(halted), .TRAP_REQ(trap), .ACK(ack),
    .ACK_SRC(ack_src), .IRQ(irq), .IRQ_SRC(isrc), .IRQ_VECTOR(vec),
    .IRQ_LEVEL(), .WAKE(wake));

  nim_cpu_model cpu (.clk(clk), .rst_n(rstn), .en(ben), .dly(dly),
    .irq(irq), .irq_src(isrc), .ack(ack), .ack_src(ack_src));
  //////////////////////////////////////////////////////////////////////////
  function automatic int pw(int o, int v);
    int r;
    r = v & 8'hFF;
    for (int i = 0; i < 8; i += 2)
      if (((v >> i) & 3) == 2) r = (r & ~(3 << i)) | (o & (3 << i));
    return r;
  endfunction

  function automatic int ew(int o, int v, int l);
    int r;
    r = (l == 3) ? v & 8'hFC : o & 8'hFC;
    r |= (o & 1) ? o & 2 : v & 2;
    return r | (v & 1);
  endfunction

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(string s, logic [31:0] v, logic [31:0] x);
    checked++;
    if (v !== x) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", s, x, v);
    end
  endtask

  task automatic bail;
    fail_count++;
    close_out();
  endtask

  task automatic apb(logic w, logic [7:0] i, logic [31:0] v);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= v;
    @(posedge clk);
    pen <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) bail();
    q = prdata;
    psel <= 0;
    pen <= 0;
  endtask

  // 0 waits for a request, 1 for routine entry
  task automatic wsig(int a);
    for (n = 0; n < 200 && (a ? ack : irq) !== 1'b1; n++) @(posedge clk);
    if (n == 200) bail();
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(6937));
    repeat (16) @(posedge clk);
    rstn <= 1;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      apb(0, i < 5 ? 8'(8'h24 + i) : 8'h10, 0);
      chk("reset", q, i < 4 ? 32'hFF : 32'h0);
      prio[i % 4] = 255;
    end
    repeat (8) begin
      k = $urandom % 4;
      d = $urandom;
      apb(1, 8'(8'h24 + k), d);
      prio[k] = pw(prio[k], d) | (k == 3 ? 8'hF0 : 0);
      apb(0, 8'(8'h24 + k), 0);
      chk("prio", q, prio[k]);
    end
    for (int i = 0; i < 4; i++) apb(1, 8'(8'h24 + i), 32'hFF);
    apb(1, 8'h29, 32'h2);
    apb(1, 8'h28, 32'hFC);
    ext = ew(ext, 8'hFC, 0);
    apb(0, 8'h28, 0);
    chk("locked", q, ext);
    // level 3, every peripheral source disabled: only pending flags and WAKE move
    apb(1, 8'h29, 32'h3);
    for (int c = 0; c < 32; c++) begin
      {g, code, pol, dir} = 5'(c);
      k = $urandom % 3;
      sel = 4'($urandom) | 4'(1 << k);
      p0 = (dir ? 4'h0 : sel) | (4'($urandom) & ~sel);
      p1 = (dir ? 4'(1 << k) : 4'h0) | (4'($urandom) & ~sel);
      cfg = g ? {code, pol, 5'h0} : {3'h0, code, pol, 2'h0};
      pa <= p0;
      pf <= p0[2:0];
      pb <= {p0, p0};
      pa_sel <= g ? 4'h0 : sel;
      pf_sel <= g ? 3'h0 : sel[2:0];
      pb_sel <= g ? {sel, sel} : 8'h00;
      repeat (8) @(posedge clk);
      apb(1, 8'h28, 32'hFC);
      apb(1, 8'h28, cfg);
      ext = cfg;
      repeat (2) @(posedge clk);
      pa <= p1;
      pf <= p1[2:0];
      pb <= {p1, p1};
      repeat (8) @(posedge clk);
      apb(0, 8'h2A, 0);
      e0 = code == 3 || ((code == 1) == (dir ^ pol));
      e1 = code == 3 || ((code == 1) == dir);
      chk("pend", q[g ? 4 : 2], e0);
      chk("pend_raw", q[g ? 5 : 3], e1);
    end
    pa <= 4'hF;
    pb <= 8'hFF;
    pf <= 3'h7;
    repeat (8) @(posedge clk);
    apb(1, 8'h28, 32'h90);
    ext = 8'h90;
    per <= 14'h3F82;
    apb(1, 8'h29, 32'h2);
    repeat (10) @(posedge clk);
    chk("masked", irq, 0);
    apb(1, 8'h29, 32'h3FFF0003);
    repeat (10) @(posedge clk);
    chk("level", irq, 0);
    ben <= 1;
    foreach (srcs[i]) begin
      dly <= 3'($urandom);
      apb(1, 8'h29, 32'h3FFF0002);
      wsig(0);
      chk("src", isrc, srcs[i]);
      chk("vec", vec, 16'hFFFA - 2 * srcs[i]);
      wsig(1);
      per[srcs[i]] <= 0;
    end
    ben <= 0;
    halted <= 1;
    apb(1, 8'h29, 32'h3FFF0002);
    foreach (srcs[i]) for (int m = 0; m < 2; m++) begin
      per[srcs[i]] <= 1;
      slave <= 1'(m);
      extck <= 1'(m);
      repeat (4) @(posedge clk);
      e0 = srcs[i] == 1 || m && srcs[i] % 6 == 1;
      chk("wake", wake, e0);
      per <= 0;
      repeat (4) @(posedge clk);
    end
    halted <= 0;
    ben <= 1;
    apb(1, 8'h29, 32'h3FFF0003);
    foreach (tw[i]) begin
      apb(1, 8'h28, tw[i]);
      ext = ew(ext, tw[i], 3);
    end
    apb(0, 8'h28, 0);
    chk("top_cfg", q, ext);
    top <= 1;
    wsig(0);
    chk("top_src", isrc, 0);
    chk("top_vec", vec, 16'hFFFA);
    wsig(1);
    // clearing the enable may leave one stray request behind
    apb(1, 8'h28, 32'h90);
    repeat (10) @(posedge clk);
    trap <= 1;
    wsig(0);
    chk("trap_vec", vec, 16'hFFFC);
    wsig(1);
    trap <= 0;
    repeat (10) @(posedge clk);
    close_out();
  end
endmodule
